/* File: core/atrc_torque_ramp.sv */
// torque ramp command block for one servo axis, evaluated once per scan cycle
// Operation
// - raise target-reached once the ramped command equals the target torque
// - busy rises in the same cycle as the enable rising edge
// - active high only while the block controls the axis
// - busy and active drop when target-reached or error becomes true
// - enable falling clears busy, active and target-reached
// - preemption by halt sets preempted, clears target-reached, busy, active
// - preempted holds until enable goes false
// - preemption after enable fell pulses preempted for exactly one cycle
// - illegal parameters or execution faults are errors
// - bad parameters: busy first, one cycle later error, busy low, fault code
// - enable falling with error clears error and zeroes fault code
// - fault code is 16 bits, valid while error is true
// - command torque ramps toward target at configured rate
// - target change mid-run ramps to new value at once, then holds
// - speed command never exceeds the configured maximum velocity; this block only hands it to the drive as velocity_limit_o
// - enable falling leaves torque mode at once, ignoring the rate
// - torque is signed thousandths of rated torque
// - direction code 1 positive, 3 negative, sampled at enable rise
// - target torque changes apply immediately while enable is true
`timescale 1ns/1ps
// one clock edge is one controller scan: inputs are sampled, the ramp steps
// once and every flag and code is registered, so the host sees each change a
// scan after the input that caused it. torque_cmd_o is a signed value and is
// zeroed whenever torque mode is left; velocity_limit_o and dir_negative_o
// hold what was captured at the last enable rise. slope_rate_i is a step per
// scan; a host that thinks in rate per second divides by the scan rate.
// the speed ceiling is handed to the drive, which does the actual limiting;
// this block never measures axis speed itself.
module atrc_torque_ramp
    import atrc_pkg::*;
(
    input  wire logic                ref_clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                enable_i,
    input  wire logic [7:0]          axis_i,
    input  wire logic [TORQUE_W-1:0] target_torque_i,
    input  wire logic [RATE_W-1:0]   slope_rate_i,
    input  wire logic [VEL_W-1:0]    max_velocity_i,
    input  wire logic [1:0]          direction_i,
    input  wire logic                halt_instruction_i,
    input  wire logic                axis_fault_i,
    output logic                     torque_mode_o,
    output logic [TORQUE_W-1:0]      torque_cmd_o,
    output logic [VEL_W-1:0]         velocity_limit_o,
    output logic                     dir_negative_o,
    output logic                     in_torque_o,
    output logic                     busy_o,
    output logic                     active_o,
    output logic                     preempted_flag_o,
    output logic                     error_o,
    output logic [FAULT_W-1:0]       fault_code_o
);

    // parameter check at the enable rise; the first illegal field decides the code,
    // so a host fixing one field may see the next one reported on the retry
    function automatic logic [FAULT_W-1:0] atrc_check(input logic [7:0]        axis,
                                                      input logic [1:0]        dir,
                                                      input logic [RATE_W-1:0] rate,
                                                      input logic [VEL_W-1:0]  vel);
        logic [FAULT_W-1:0] code;
        code = FAULT_NONE;
        if (axis == AXIS_ILLEGAL) begin
            code = FAULT_BAD_AXIS;
        end else if (dir != DIR_POSITIVE && dir != DIR_NEGATIVE) begin
            code = FAULT_BAD_DIR;
        end else if (rate == '0) begin
            code = FAULT_BAD_RATE;
        end else if (vel == '0) begin
            code = FAULT_BAD_VEL;
        end
        return code;
    endfunction : atrc_check

    // one ramp step toward the target, rate taken as positive magnitude;
    // torque is signed thousandths of rated torque, so both ends are sign
    // extended by two bits and a full-scale swing cannot wrap
    function automatic logic [TORQUE_W-1:0] atrc_step(input logic [TORQUE_W-1:0] cur,
                                                      input logic [TORQUE_W-1:0] tgt,
                                                      input logic [RATE_W-1:0] rate);
        logic signed [TORQUE_W+1:0] diff;
        logic signed [TORQUE_W+1:0] mag;
        diff = $signed({{2{tgt[TORQUE_W-1]}}, tgt}) - $signed({{2{cur[TORQUE_W-1]}}, cur});
        mag  = $signed({2'b00, rate});
        // clip the step to the rate in either direction
        if (diff > mag) begin
            diff = mag;
        end else if (diff < -mag) begin
            diff = -mag;
        end
        return TORQUE_W'($signed({{2{cur[TORQUE_W-1]}}, cur}) + diff);
    endfunction : atrc_step

    // sequencing state and the enable level seen at the last scan
    atrc_state_t         state;
    atrc_state_t         next_state;
    logic                enable_d;
    logic                next_enable_d;

    // next values of the registered outputs
    logic [TORQUE_W-1:0] next_torque_cmd;
    logic [VEL_W-1:0]    next_velocity_limit;
    logic                next_dir_negative;
    logic                next_torque_mode;
    logic                next_in_torque;
    logic                next_busy;
    logic                next_active;
    logic                next_preempted;
    logic                next_error;
    logic [FAULT_W-1:0]  next_fault_code;

    // check result and parameters captured at the enable rise
    logic [FAULT_W-1:0]  check_code;
    logic [FAULT_W-1:0]  pending_code;
    logic [FAULT_W-1:0]  next_pending_code;
    logic [RATE_W-1:0]   rate;
    logic [RATE_W-1:0]   next_rate;

    // enable edges against the registered level; enable_d resets low, so
    // an enable already high when reset lifts counts as a rise
    logic                rise;
    logic                fall;

    // edge detection and the parameter check are pure decode of this scan
    assign rise       = enable_i & ~enable_d;
    assign fall       = ~enable_i & enable_d;
    assign check_code = atrc_check(axis_i, direction_i, slope_rate_i, max_velocity_i);

    // state walk, one step per scan:
    //   idle     -> check   on an enable rise, busy raised at once
    //   check    -> error   when the captured check found an illegal field
    //   check    -> run     otherwise; axis taken into torque mode, active high
    //   run      -> done    when the ramped command lands on the target
    //   done     -> run     when the target moves again while enable stays high
    //   run/done -> error on an axis fault, aborted on a halt (idle if enable is low), idle on a fall
    //   error    -> idle    once enable is seen low, flag and code cleared
    //   aborted  -> idle    once enable is seen low, preempted cleared
    // rises seen outside idle are ignored; the host must drop enable first
    always_comb begin
        next_state          = state;
        next_enable_d       = enable_i;
        next_torque_cmd     = torque_cmd_o;
        next_velocity_limit = velocity_limit_o;
        next_dir_negative   = dir_negative_o;
        next_rate           = rate;
        next_torque_mode    = torque_mode_o;
        next_in_torque      = in_torque_o;
        next_busy           = busy_o;
        next_active         = active_o;
        next_preempted      = preempted_flag_o;
        next_error          = error_o;
        next_fault_code     = fault_code_o;
        next_pending_code   = pending_code;
        unique case (state)
            // waiting for a command; a preempted pulse from a late halt ends here
            ATRC_IDLE: begin
                next_preempted = 1'b0; // single-cycle pulse ends here
                if (rise) begin
                    next_busy           = 1'b1;
                    next_velocity_limit = max_velocity_i;
                    next_dir_negative   = (direction_i == DIR_NEGATIVE); // sampled at rise
                    next_rate           = slope_rate_i;
                    next_pending_code   = check_code; // held back until error shows
                    next_state          = ATRC_CHECK;
                end
            end

            // busy alone for one scan, then either error with its code or control
            ATRC_CHECK: begin
                // the code is held back a scan so busy is seen before error and code
                if (pending_code != FAULT_NONE) begin
                    next_busy       = 1'b0;
                    next_error      = 1'b1;
                    next_fault_code = pending_code;
                    next_state = ATRC_ERROR;
                end else begin
                    next_active      = 1'b1;
                    next_torque_mode = 1'b1;
                    next_state       = ATRC_RUN;
                end
                // enable dropped during the check: nothing has started, so all clears
                if (!enable_i) begin
                    next_busy       = 1'b0;
                    next_active     = 1'b0;
                    next_error      = 1'b0;
                    next_fault_code = FAULT_NONE;
                    next_torque_mode = 1'b0;
                    next_state      = ATRC_IDLE;
                end
            end

            // torque control proper; done differs from run only in the flags
            ATRC_RUN, ATRC_DONE: begin
                // ramp each scan; target followed live
                next_torque_cmd = atrc_step(torque_cmd_o, target_torque_i, rate);
                // arrived: the flags flip in the same scan the command lands
                if (next_torque_cmd == target_torque_i) begin
                    next_in_torque = 1'b1;
                    next_busy      = 1'b0;
                    next_active    = 1'b0;
                    next_state     = ATRC_DONE;
                end else begin
                    // target moved after arrival: ramp again, hold when reached
                    next_in_torque = 1'b0;
                    next_busy      = 1'b1;
                    next_active    = 1'b1;
                    next_state     = ATRC_RUN;
                end
                // exits ranked: axis fault first, then halt, then enable fall;
                // each drops torque mode and zeroes the command in this scan,
                // so a fault seen with a halt still reports the fault code
                if (axis_fault_i) begin
                    next_error       = 1'b1;
                    next_fault_code  = FAULT_AXIS;
                    next_in_torque   = 1'b0;
                    next_busy        = 1'b0;
                    next_active      = 1'b0;
                    next_torque_mode = 1'b0;
                    next_torque_cmd  = TORQUE_RESET;
                    next_state       = ATRC_ERROR;
                end else if (halt_instruction_i) begin
                    next_preempted   = 1'b1;
                    next_in_torque   = 1'b0;
                    next_busy        = 1'b0;
                    next_active      = 1'b0;
                    next_torque_mode = 1'b0;
                    next_torque_cmd  = TORQUE_RESET;
                    next_state       = enable_i ? ATRC_ABORTED : ATRC_IDLE; // pulse if enable gone
                end else if (fall) begin
                    // leave torque mode at once, no ramp down
                    // enable was high at every scan spent here, so a low level is a fall
                    next_torque_mode = 1'b0;
                    next_torque_cmd  = TORQUE_RESET;
                    next_in_torque   = 1'b0;
                    next_busy        = 1'b0;
                    next_active      = 1'b0;
                    next_state       = ATRC_IDLE;
                end
            end

            // error held until enable is seen low
            ATRC_ERROR: begin
                if (!enable_i) begin
                    next_error      = 1'b0;
                    next_fault_code = FAULT_NONE;
                    next_state      = ATRC_IDLE;
                end
            end

            // preempted held while enable stays high
            ATRC_ABORTED: begin
                if (!enable_i) begin
                    next_preempted = 1'b0;
                    next_state     = ATRC_IDLE;
                end
            end

            // codes 6 and 7 are unused; a stray state falls back to idle
            default: begin
                next_state = ATRC_IDLE;
            end
        endcase
    end

    // register stage; all outputs come from here
    // async reset loads constants only, so every output is known from the first edge
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state            <= ATRC_IDLE;
            enable_d         <= 1'b0;
            torque_cmd_o     <= TORQUE_RESET;
            velocity_limit_o <= '0;
            dir_negative_o   <= 1'b0;
            rate             <= '0;
            torque_mode_o    <= 1'b0;
            in_torque_o      <= 1'b0;
            busy_o           <= 1'b0;
            active_o         <= 1'b0;
            preempted_flag_o <= 1'b0;
            error_o          <= 1'b0;
            fault_code_o     <= FAULT_NONE;
            pending_code     <= FAULT_NONE;
        end else begin
            state            <= next_state;
            enable_d         <= next_enable_d;
            torque_cmd_o     <= next_torque_cmd;
            velocity_limit_o <= next_velocity_limit; // speed ceiling to the drive
            dir_negative_o   <= next_dir_negative;
            rate             <= next_rate;
            torque_mode_o    <= next_torque_mode;
            in_torque_o      <= next_in_torque;
            busy_o           <= next_busy;
            active_o         <= next_active;
            preempted_flag_o <= next_preempted;
            error_o          <= next_error;
            fault_code_o     <= next_fault_code;
            pending_code     <= next_pending_code;
        end
    end

endmodule : atrc_torque_ramp

/* File: core/atrc_pkg.sv */
// package: constants and types for the axis torque ramp control block
package atrc_pkg;
    localparam int          TORQUE_W       = 16;
    localparam int          RATE_W         = 16;
    localparam int          VEL_W          = 32;
    localparam int          FAULT_W        = 16;
    localparam logic [7:0]  AXIS_ILLEGAL   = 8'h00;
    localparam logic [1:0]  DIR_POSITIVE   = 2'h1;
    localparam logic [1:0]  DIR_NEGATIVE   = 2'h3;
    localparam logic [15:0] FAULT_NONE     = 16'h0000;
    localparam logic [15:0] FAULT_BAD_AXIS = 16'h0001; // arbitrary code value
    localparam logic [15:0] FAULT_BAD_DIR  = 16'h0002; // arbitrary code value
    localparam logic [15:0] FAULT_BAD_RATE = 16'h0003; // arbitrary code value
    localparam logic [15:0] FAULT_BAD_VEL  = 16'h0004; // arbitrary code value
    localparam logic [15:0] FAULT_AXIS     = 16'h0005; // arbitrary code value
    localparam logic [15:0] TORQUE_RESET   = 16'h0000;

    typedef enum logic [2:0] {
        ATRC_IDLE    = 3'b000,
        ATRC_CHECK   = 3'b001,
        ATRC_RUN     = 3'b010,
        ATRC_DONE    = 3'b011,
        ATRC_ERROR   = 3'b100,
        ATRC_ABORTED = 3'b101
    } atrc_state_t;
endpackage : atrc_pkg

/* File: tb/atrc_axis_model.sv */
// model: servo axis that follows torque commands and can report a fault
`timescale 1ns/1ps
module atrc_axis_model
    import atrc_pkg::*;
(
    input  wire logic                ref_clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                torque_mode_i,
    input  wire logic [TORQUE_W-1:0] torque_cmd_i,
    input  wire logic                fault_req_i,
    output logic                     axis_fault_o,
    output logic [TORQUE_W-1:0]      actual_torque_o
);
    // output torque lags the command by one scan, zero outside torque mode
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            axis_fault_o    <= 1'b0;
            actual_torque_o <= TORQUE_RESET;
        end else begin
            axis_fault_o    <= fault_req_i;
            actual_torque_o <= torque_mode_i ? torque_cmd_i : TORQUE_RESET;
        end
    end
endmodule : atrc_axis_model

/* File: tb/atrc_torque_ramp_sva.sv */
// checker: cycle relations between the torque ramp block's ports
`timescale 1ns/1ps
module atrc_torque_ramp_chk
    import atrc_pkg::*;
(
    input wire logic                ref_clk_i,
    input wire logic                reset_n_i,
    input wire logic                enable_i,
    input wire logic [7:0]          axis_i,
    input wire logic [TORQUE_W-1:0] target_torque_i,
    input wire logic [RATE_W-1:0]   slope_rate_i,
    input wire logic                halt_instruction_i,
    input wire logic                axis_fault_i,
    input wire logic                torque_mode_o,
    input wire logic [TORQUE_W-1:0] torque_cmd_o,
    input wire logic                in_torque_o,
    input wire logic                busy_o,
    input wire logic                active_o,
    input wire logic                preempted_flag_o,
    input wire logic                error_o,
    input wire logic [FAULT_W-1:0]  fault_code_o
);
    logic idle;
    // a rise only counts when nothing is left over from the last command
    assign idle = !busy_o && !torque_mode_o && !error_o && !preempted_flag_o;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_busy; $rose(enable_i) && idle |=> busy_o; endproperty
    a_busy: assert property (p_busy) else $error("busy late");
    property p_bad; $rose(enable_i) && idle && axis_i == AXIS_ILLEGAL ##1 enable_i
        |=> error_o && !busy_o && fault_code_o == FAULT_BAD_AXIS; endproperty
    a_bad: assert property (p_bad) else $error("bad axis");
    property p_reach; $rose(in_torque_o) |-> !busy_o && !active_o && torque_cmd_o == $past(target_torque_i); endproperty
    a_reach: assert property (p_reach) else $error("arrival");
    property p_fall; $fell(enable_i) && !axis_fault_i
        |=> !busy_o && !active_o && !in_torque_o && !torque_mode_o && torque_cmd_o == TORQUE_RESET; endproperty
    a_fall: assert property (p_fall) else $error("fall");
    property p_halt; torque_mode_o && enable_i && halt_instruction_i && !axis_fault_i
        |=> preempted_flag_o && !busy_o && !active_o && !in_torque_o; endproperty
    a_halt: assert property (p_halt) else $error("halt");
    property p_clear; preempted_flag_o && !enable_i |=> !preempted_flag_o; endproperty
    a_clear: assert property (p_clear) else $error("preempt clear");
    property p_errclr; error_o && $fell(enable_i) |=> !error_o && fault_code_o == FAULT_NONE; endproperty
    a_errclr: assert property (p_errclr) else $error("error clear");
    property p_fault; torque_mode_o && axis_fault_i |=> error_o && !busy_o && fault_code_o == FAULT_AXIS; endproperty
    a_fault: assert property (p_fault) else $error("fault");
    // step size bounded both ways; a direct jump breaks it
    property p_slope; torque_mode_o && $past(torque_mode_o) |->
        $signed(torque_cmd_o) - $signed($past(torque_cmd_o)) <= $signed({1'b0, slope_rate_i}) &&
        $signed($past(torque_cmd_o)) - $signed(torque_cmd_o) <= $signed({1'b0, slope_rate_i}); endproperty
    a_slope: assert property (p_slope) else $error("slope");
    c_reach: cover property ($rose(in_torque_o));
    c_pre: cover property ($rose(preempted_flag_o));
    c_err: cover property ($rose(error_o));
endmodule : atrc_torque_ramp_chk
bind atrc_torque_ramp atrc_torque_ramp_chk i_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i),
    .axis_i(axis_i), .target_torque_i(target_torque_i), .slope_rate_i(slope_rate_i),
    .halt_instruction_i(halt_instruction_i), .axis_fault_i(axis_fault_i), .torque_mode_o(torque_mode_o),
    .torque_cmd_o(torque_cmd_o), .in_torque_o(in_torque_o), .busy_o(busy_o), .active_o(active_o),
    .preempted_flag_o(preempted_flag_o), .error_o(error_o), .fault_code_o(fault_code_o));

/* File: tb/test_atrc_torque_ramp.sv */
// testbench: scenario tasks for the torque ramp block
`timescale 1ns/1ps
module test_atrc_torque_ramp import atrc_pkg::*;;
    logic                ref_clk_i, reset_n_i, enable_i, halt_instruction_i, axis_fault_i, fault_req;
    logic [7:0]          axis_i;
    logic [TORQUE_W-1:0] target_torque_i, torque_cmd_o, actual;
    logic [RATE_W-1:0]   slope_rate_i;
    logic [VEL_W-1:0]    max_velocity_i, velocity_limit_o;
    logic [1:0]          direction_i;
    logic                torque_mode_o, dir_negative_o, in_torque_o, busy_o, active_o, preempted_flag_o, error_o;
    logic [FAULT_W-1:0]  fault_code_o;
    int                  errors = 0;
    int                  compares = 0;
    atrc_torque_ramp i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i), .axis_i(axis_i),
        .target_torque_i(target_torque_i), .slope_rate_i(slope_rate_i), .max_velocity_i(max_velocity_i),
        .direction_i(direction_i), .halt_instruction_i(halt_instruction_i), .axis_fault_i(axis_fault_i),
        .torque_mode_o(torque_mode_o), .torque_cmd_o(torque_cmd_o), .velocity_limit_o(velocity_limit_o),
        .dir_negative_o(dir_negative_o), .in_torque_o(in_torque_o), .busy_o(busy_o), .active_o(active_o),
        .preempted_flag_o(preempted_flag_o), .error_o(error_o), .fault_code_o(fault_code_o));
    atrc_axis_model i_axis (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .torque_mode_i(torque_mode_o),
        .torque_cmd_i(torque_cmd_o), .fault_req_i(fault_req), .axis_fault_o(axis_fault_i), .actual_torque_o(actual));
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    task automatic tick(input int n = 1);
        repeat (n) @(negedge ref_clk_i);
    endtask : tick
    task automatic chk(input bit ok, input string what);
        compares++;
        if (!ok) begin
            errors++;
            $display("ERROR %0t %s", $time, what);
        end
    endtask : chk
    // one rise edge; returns after the cycle where control or error shows
    task automatic go(input logic [7:0] ax, input logic [15:0] tq, input logic [15:0] rt, input logic [31:0] vl,
        input logic [1:0] dr);
        {axis_i, target_torque_i, slope_rate_i, max_velocity_i, direction_i} = {ax, tq, rt, vl, dr};
        enable_i = 1'b1;
        tick();
        chk(busy_o === 1'b1 && active_o === 1'b0, "busy");
        chk(error_o === 1'b0 && fault_code_o === FAULT_NONE, "early code");
        tick();
    endtask : go
    task automatic stop();
        enable_i = 1'b0;
        tick();
    endtask : stop
    task automatic t_ramp();
        int n;
        go(8'h01, 16'h001E, 16'h0008, 32'h0000_0064, DIR_POSITIVE);
        chk(active_o === 1'b1 && torque_mode_o === 1'b1, "active");
        chk(velocity_limit_o === 32'h0000_0064 && dir_negative_o === 1'b0, "latch");
        tick();
        chk(torque_cmd_o === 16'h0008, "step");
        tick(3);
        chk(in_torque_o === 1'b1 && torque_cmd_o === 16'h001E && busy_o === 1'b0, "reach");
        target_torque_i = 16'hFFEC;
        tick();
        chk(in_torque_o === 1'b0 && busy_o === 1'b1 && torque_cmd_o === 16'h0016, "leave");
        for (n = 1; n < 40 && in_torque_o !== 1'b1; n++) tick();
        chk(n == 7 && torque_cmd_o === 16'hFFEC, "retarget");
        target_torque_i = 16'h0000;
        for (n = 0; n < 40 && actual !== 16'h0000; n++) tick();
        chk(actual === 16'h0000 && torque_cmd_o === 16'h0000, "settle");
        stop();
        chk(torque_mode_o === 1'b0 && in_torque_o === 1'b0 && torque_cmd_o === 16'h0000, "exit");
        $display("ramp test done");
    endtask : t_ramp
    task automatic t_drop();
        go(8'h02, 16'h0190, 16'h0005, 32'h0000_0010, DIR_NEGATIVE);
        chk(dir_negative_o === 1'b1, "dir");
        tick(3);
        stop();
        chk(torque_cmd_o === 16'h0000 && busy_o === 1'b0 && active_o === 1'b0, "drop");
        $display("drop test done");
    endtask : t_drop
    task automatic t_halt(input bit late);
        go(8'h01, 16'h0064, 16'h0004, 32'h0000_0020, DIR_POSITIVE);
        tick(2);
        enable_i = !late;
        halt_instruction_i = 1'b1;
        tick();
        halt_instruction_i = 1'b0;
        chk(preempted_flag_o === 1'b1 && busy_o === 1'b0 && active_o === 1'b0, "preempt");
        tick(late ? 1 : 3);
        chk(preempted_flag_o === !late, "hold");
        stop();
        chk(preempted_flag_o === 1'b0, "release");
        $display("halt test done");
    endtask : t_halt
    task automatic t_bad();
        logic [15:0] codes [4] = '{FAULT_BAD_AXIS, FAULT_BAD_DIR, FAULT_BAD_RATE, FAULT_BAD_VEL};
        for (int i = 0; i < 4; i++) begin
            go(i == 0 ? 8'h00 : 8'h01, 16'h0010, i == 2 ? 16'h0000 : 16'h0004, i == 3 ? 32'h0 : 32'h64,
                i == 1 ? 2'h2 : DIR_POSITIVE);
            chk(error_o === 1'b1 && busy_o === 1'b0 && fault_code_o === codes[i], "code");
            stop();
            chk(error_o === 1'b0 && fault_code_o === FAULT_NONE, "clear");
        end
        go(8'h01, 16'h00C8, 16'h0002, 32'h0000_0020, DIR_POSITIVE);
        fault_req = 1'b1;
        tick(2);
        fault_req = 1'b0;
        chk(error_o === 1'b1 && active_o === 1'b0 && fault_code_o === FAULT_AXIS, "fault");
        stop();
        $display("error test done");
    endtask : t_bad
    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // the whole sequence needs about 63 cycles; the limit is 2000
    initial begin
        #(2000 * 50);
        errors++;
        wrap_up();
    end
    initial begin
        {enable_i, halt_instruction_i, fault_req, axis_i, target_torque_i} = '0;
        {slope_rate_i, max_velocity_i, direction_i} = '0;
        reset_n_i = 1'b0;
        tick(5);
        reset_n_i = 1'b1;
        tick();
        t_ramp();
        t_drop();
        t_halt(1'b0);
        t_halt(1'b1);
        t_bad();
        wrap_up();
    end
endmodule : test_atrc_torque_ramp
